// >>> rtl/fcfb_pkg.sv
package fcfb_pkg;

  // ============================================================
  // apb register map (byte addresses)
  // ============================================================
  localparam logic [11:0] FCFB_CTRL_ADDR = 12'h000;
  localparam logic [11:0] FCFB_THR_ADDR = 12'h004;
  localparam logic [11:0] FCFB_CQ_PART_ADDR = 12'h008;
  localparam logic [11:0] FCFB_DQ_PART_ADDR = 12'h00C;
  localparam logic [11:0] FCFB_STATUS_ADDR = 12'h010;
  localparam logic [11:0] FCFB_STICKY_ADDR = 12'h014;
  localparam logic [11:0] FCFB_DROP_CQ_OVF_ADDR = 12'h018;
  localparam logic [11:0] FCFB_DROP_DQ_OVF_ADDR = 12'h01C;
  localparam logic [11:0] FCFB_DROP_CQ_ECC_ADDR = 12'h020;
  localparam logic [11:0] FCFB_DROP_DQ_ECC_ADDR = 12'h024;
  localparam logic [11:0] FCFB_DROP_IG_ECC_ADDR = 12'h028;
  localparam logic [11:0] FCFB_LPI_WAKE_ADDR = 12'h02C;

  // ============================================================
  // control field positions and reset values
  // ============================================================
  localparam int FCFB_CTRL_REACT_BIT = 0;
  localparam int FCFB_CTRL_GEN_BIT = 1;
  localparam int FCFB_CTRL_MERGE_BIT = 2;
  localparam int FCFB_CTRL_CQ_BIT = 3;
  localparam int FCFB_CTRL_EEE_BIT = 4;
  localparam int FCFB_CTRL_WAN_BIT = 5;
  localparam logic [31:0] FCFB_CTRL_RST = 32'h0000000F;
  localparam int FCFB_HI_LSB = 16;
  localparam int FCFB_PTR_W = 9;
  localparam logic [FCFB_PTR_W-1:0] FCFB_XOFF_RST = 9'h100;
  localparam logic [FCFB_PTR_W-1:0] FCFB_XON_RST = 9'h080;
  localparam logic [FCFB_PTR_W-1:0] FCFB_CQ_START_RST = 9'h000;
  localparam logic [FCFB_PTR_W-1:0] FCFB_CQ_END_RST = 9'h03F;
  localparam logic [FCFB_PTR_W-1:0] FCFB_DQ_START_RST = 9'h040;
  localparam logic [FCFB_PTR_W-1:0] FCFB_DQ_END_RST = 9'h1FF;
  localparam logic [15:0] FCFB_WAKE_RST = 16'h0010;

  // pause quanta scale: 512 bit times over 64-bit word = 8 words
  localparam int FCFB_QUANTA_SHIFT = 3;
  // wan mode drains one word less in every 16 cycles, skipping at this rate count
  localparam logic [3:0] FCFB_WAN_SKIP = 4'hF;

  // sticky bit positions
  localparam int FCFB_STK_CQ_OVF = 0;
  localparam int FCFB_STK_DQ_OVF = 1;
  localparam int FCFB_STK_CQ_ECC = 2;
  localparam int FCFB_STK_DQ_ECC = 3;
  localparam int FCFB_STK_IG_ECC = 4;
  localparam int FCFB_STK_N = 5;

  // in-band word kinds: data word or special control word
  typedef enum logic [1:0] {
    FCFB_K_DATA,
    FCFB_K_LINK_FAULT,
    FCFB_K_LPI
  } fcfb_kind_t;

  typedef struct packed {
    logic [63:0] data;
    logic sof;
    logic eof;
    logic ctrl;
    fcfb_kind_t kind;
  } fcfb_word_t;

endpackage

// >>> rtl/fcfb_queue.sv
`timescale 1ns/1ps
module fcfb_queue
  import fcfb_pkg::*;
#(
  parameter int AW = FCFB_PTR_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // partition of shared memory
  input wire logic [AW-1:0] start_i,
  input wire logic [AW-1:0] end_i,
  // shared memory ports
  output logic [AW-1:0] waddr_o,
  output logic [AW-1:0] raddr_o,
  // write side
  input wire logic push_i,
  // read side
  input wire logic pop_i,
  // status
  output logic empty_o,
  output logic full_o,
  output logic [AW:0] level_o
);

  // ============================================================
  // circular pointers inside the region start..end
  // ============================================================
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] size;

  assign size = {1'b0, end_i} - {1'b0, start_i} + {{AW{1'b0}}, 1'b1};
  assign waddr_o = wp_ff;
  assign raddr_o = rp_ff;
  assign empty_o = (cnt_ff == '0);
  assign full_o = (cnt_ff >= size);
  assign level_o = cnt_ff;

  function automatic logic [AW-1:0] adv(input logic [AW-1:0] p,
                                        input logic [AW-1:0] s,
                                        input logic [AW-1:0] e);
    adv = (p == e) ? s : p + 1'b1;
  endfunction

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (wp_ff < start_i || wp_ff > end_i) begin
        wp_ff <= start_i;
        rp_ff <= start_i;
        cnt_ff <= '0;
      end else begin
        if (push_i) begin
          wp_ff <= adv(wp_ff, start_i, end_i);
        end
        if (pop_i) begin
          rp_ff <= adv(rp_ff, start_i, end_i);
        end
        cnt_ff <= cnt_ff + (push_i ? 1'b1 : 1'b0) - (pop_i ? 1'b1 : 1'b0);
      end
    end
  end

endmodule

// >>> rtl/fcfb_egress.sv
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - egress store absorbs frame growth; back-pressure host when full, except a control frame starting into a full control queue is dropped
// - two queues, control queue strictly preferred over data
// - control frames forwarded to line even while paused
// - egress memory sized to at least four MTUs
// - drops counted and latched in sticky status bits
// - fault and lpi control words relayed in-band from host to line
// - eee state machine enters low-power idle and wakes up
// - rate adaptation between clocks incl. lan/wan rate difference
// - received pause entered only at next frame boundary
// - pause timer kept here, started once pause state entered
// - paused: data drain stops, control frames still drain, fill continues at full rate
// - pause request to host from xoff/xon thresholds
// - after xoff, room remains for one jumbo frame
// - line pause reaction enable gates pause state and timer
// - threshold pause request enable gates xon/xoff signalling
// - merge setting ors received pause into host request
// - host pause frames arrive here as control frames
// - at frame boundary queued control frames go before data
// - control queue enable decides whether control queue exists
// - memory split by start/end fields per queue
// - advanced mode: gen on, react, merge, control queue off
// - advanced mode: request purely from thresholds
// - drop counters 32-bit, wrap to zero
// - uncorrectable ecc read aborts frame, counted per queue
module fcfb_egress
  import fcfb_pkg::*;
#(
  parameter int AW = FCFB_PTR_W,
  parameter int MTU_WORDS = 64
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // host side egress input
  input wire logic in_valid_i,
  input wire fcfb_word_t in_word_i,
  output logic in_ready_o,
  // line side egress output
  output logic out_valid_o,
  output fcfb_word_t out_word_o,
  output logic out_abort_o,
  input wire logic out_ready_i,
  // ecc check result of the memory read
  input wire logic ecc_uncorr_i,
  // ingress ecc failure pulse
  input wire logic ig_ecc_fail_i,
  // pause received from line mac rx
  input wire logic line_pause_i,
  input wire logic [15:0] line_quanta_i,
  // pause request to host mac tx
  output logic host_pause_req_o,
  // eee status
  output logic lpi_active_o
);

  // ============================================================
  // registers and memory
  // ============================================================
  localparam int DEPTH = 1 << AW;
  fcfb_word_t mem [DEPTH];
  logic [31:0] ctrl_ff, thr_ff, cqp_ff, dqp_ff, wake_ff;
  logic [FCFB_STK_N-1:0] stk_ff;
  logic [31:0] cnt_ff [FCFB_STK_N];
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] rd;
  logic rd_ok;
  logic wr_acc;
  logic react, gen, merge, cq_en, eee_en, wan;

  assign react = ctrl_ff[FCFB_CTRL_REACT_BIT];
  assign gen = ctrl_ff[FCFB_CTRL_GEN_BIT];
  assign merge = ctrl_ff[FCFB_CTRL_MERGE_BIT];
  assign cq_en = ctrl_ff[FCFB_CTRL_CQ_BIT];
  assign eee_en = ctrl_ff[FCFB_CTRL_EEE_BIT];
  assign wan = ctrl_ff[FCFB_CTRL_WAN_BIT];

  // ============================================================
  // queues
  // ============================================================
  logic cq_push, dq_push, cq_pop, dq_pop;
  logic cq_empty, dq_empty, cq_full, dq_full;
  logic [AW-1:0] cq_wa, cq_ra, dq_wa, dq_ra;
  logic [AW:0] cq_lvl, dq_lvl;
  logic to_cq;
  logic in_drop_ff;
  logic in_cq_ff;
  logic in_fire;

  // host pause frames classed as control
  assign to_cq = cq_en && in_word_i.ctrl;
  assign in_ready_o = !(to_cq ? cq_full : dq_full) || in_drop_ff;
  assign in_fire = in_valid_i && in_ready_o;
  assign cq_push = in_fire && to_cq && !in_drop_ff;
  assign dq_push = in_fire && !to_cq && !in_drop_ff;

  fcfb_queue #(.AW(AW)) u_cq (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .start_i(cqp_ff[AW-1:0]),
    .end_i(cqp_ff[FCFB_HI_LSB +: AW]),
    .waddr_o(cq_wa),
    .raddr_o(cq_ra),
    .push_i(cq_push),
    .pop_i(cq_pop),
    .empty_o(cq_empty),
    .full_o(cq_full),
    .level_o(cq_lvl)
  );

  fcfb_queue #(.AW(AW)) u_dq (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .start_i(dqp_ff[AW-1:0]),
    .end_i(dqp_ff[FCFB_HI_LSB +: AW]),
    .waddr_o(dq_wa),
    .raddr_o(dq_ra),
    .push_i(dq_push),
    .pop_i(dq_pop),
    .empty_o(dq_empty),
    .full_o(dq_full),
    .level_o(dq_lvl)
  );

  // overflow drop: a control frame that starts into a full queue
  // while back-pressure disabled is not possible; drop only when
  // control queue is full at sof and data keeps flowing
  logic cq_ovf;
  assign cq_ovf = in_valid_i && to_cq && cq_full && in_word_i.sof;
  logic dq_ovf;
  assign dq_ovf = 1'b0;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_drop_ff <= 1'b0;
      in_cq_ff <= 1'b0;
    end else if (in_fire && in_word_i.eof) begin
      in_drop_ff <= 1'b0;
    end else if (cq_ovf) begin
      in_drop_ff <= 1'b1;
      in_cq_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (cq_push) begin
      mem[cq_wa] <= in_word_i;
    end
    if (dq_push) begin
      mem[dq_wa] <= in_word_i;
    end
  end

  // ============================================================
  // pause state and timer
  // ============================================================
  logic pend_ff, paused_ff, in_frame_ff, sel_cq_ff;
  logic [18:0] ptimer_ff;
  logic [15:0] pquanta_ff;
  logic boundary;

  assign boundary = !in_frame_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_ff <= 1'b0;
      paused_ff <= 1'b0;
      ptimer_ff <= '0;
      pquanta_ff <= '0;
    end else if (!react) begin
      pend_ff <= 1'b0;
      paused_ff <= 1'b0;
      ptimer_ff <= '0;
    end else begin
      if (line_pause_i) begin
        pend_ff <= 1'b1;
        pquanta_ff <= line_quanta_i;
      end
      if ((pend_ff || line_pause_i) && boundary) begin
        pend_ff <= 1'b0;
        paused_ff <= 1'b1;
        ptimer_ff <= {line_pause_i ? line_quanta_i : pquanta_ff,
                      {FCFB_QUANTA_SHIFT{1'b0}}};
      end else if (paused_ff) begin
        if (ptimer_ff == '0) begin
          paused_ff <= 1'b0;
        end else begin
          ptimer_ff <= ptimer_ff - 1'b1;
        end
      end
    end
  end

  // ============================================================
  // scheduler and drain
  // ============================================================
  logic [3:0] rate_ff;
  logic rate_ok;
  logic eee_sleep;
  logic can_go;
  logic pick_cq;
  logic cur_cq;
  logic cur_empty;
  logic fire;

  // wan mode trims drain rate, ppm slack via handshake
  assign rate_ok = !(wan && rate_ff == FCFB_WAN_SKIP);
  // control chosen at boundary ahead of data
  assign pick_cq = !cq_empty;
  assign cur_cq = in_frame_ff ? sel_cq_ff : pick_cq;
  assign cur_empty = cur_cq ? cq_empty : dq_empty;
  // control frames go even while paused
  assign can_go = !cur_empty && rate_ok && !eee_sleep &&
                  (cur_cq || !paused_ff || (in_frame_ff && !sel_cq_ff));
  assign fire = can_go && (!out_valid_o || out_ready_i);
  assign cq_pop = fire && cur_cq;
  assign dq_pop = fire && !cur_cq;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rate_ff <= '0;
    end else begin
      rate_ff <= rate_ff + 1'b1;
    end
  end

  logic abort_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_valid_o <= 1'b0;
      out_word_o <= '0;
      out_abort_o <= 1'b0;
      in_frame_ff <= 1'b0;
      sel_cq_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      if (fire) begin
        out_valid_o <= 1'b1;
        out_word_o <= mem[cur_cq ? cq_ra : dq_ra];
        out_abort_o <= ecc_uncorr_i || abort_ff;
        sel_cq_ff <= cur_cq;
        in_frame_ff <= !mem[cur_cq ? cq_ra : dq_ra].eof;
        abort_ff <= (ecc_uncorr_i || abort_ff) &&
                    !mem[cur_cq ? cq_ra : dq_ra].eof;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
        out_abort_o <= 1'b0;
      end
    end
  end

  // ============================================================
  // eee controller
  // ============================================================
  typedef enum logic [1:0] {FCFB_ACTIVE, FCFB_SLEEP, FCFB_WAKE} fcfb_eee_t;
  fcfb_eee_t eee_ff;
  logic [15:0] wk_ff;
  logic lpi_in;

  // lpi control word passes in-band, also steers eee
  assign lpi_in = cur_empty ? 1'b0 :
                  (mem[cur_cq ? cq_ra : dq_ra].kind == FCFB_K_LPI);
  assign eee_sleep = (eee_ff != FCFB_ACTIVE);

  // enter lpi when idle, wake after wake time
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eee_ff <= FCFB_ACTIVE;
      wk_ff <= '0;
      lpi_active_o <= 1'b0;
    end else begin
      case (eee_ff)
        FCFB_ACTIVE: begin
          if (eee_en && cq_empty && dq_empty && boundary) begin
            eee_ff <= FCFB_SLEEP;
            lpi_active_o <= 1'b1;
          end
        end
        FCFB_SLEEP: begin
          if (!eee_en || !cq_empty || !dq_empty || lpi_in) begin
            eee_ff <= FCFB_WAKE;
            wk_ff <= wake_ff[15:0];
            lpi_active_o <= 1'b0;
          end
        end
        FCFB_WAKE: begin
          if (wk_ff == '0) begin
            eee_ff <= FCFB_ACTIVE;
          end else begin
            wk_ff <= wk_ff - 1'b1;
          end
        end
        default: eee_ff <= FCFB_ACTIVE;
      endcase
    end
  end

  // ============================================================
  // pause request toward host
  // ============================================================
  logic thr_req_ff;
  logic [AW:0] fill;
  assign fill = dq_lvl;

  // xoff default leaves a jumbo of room
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      thr_req_ff <= 1'b0;
    end else if (!gen) begin
      thr_req_ff <= 1'b0;
    end else if (fill >= {1'b0, thr_ff[AW-1:0]}) begin
      thr_req_ff <= 1'b1;
    end else if (fill <= {1'b0, thr_ff[FCFB_HI_LSB +: AW]}) begin
      thr_req_ff <= 1'b0;
    end
  end

  // merge received pause; thresholds only when off
  // advanced mode is merge=0 react=0 cq=0 gen=1
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_pause_req_o <= 1'b0;
    end else begin
      host_pause_req_o <= thr_req_ff ||
                          (merge && (paused_ff || pend_ff));
    end
  end

  // ============================================================
  // drop statistics and sticky bits
  // ============================================================
  logic [FCFB_STK_N-1:0] ev;
  logic sticky_wr;
  assign ev[FCFB_STK_CQ_OVF] = cq_ovf && !in_drop_ff;
  assign ev[FCFB_STK_DQ_OVF] = dq_ovf;
  assign ev[FCFB_STK_CQ_ECC] = fire && cur_cq && ecc_uncorr_i && !abort_ff;
  assign ev[FCFB_STK_DQ_ECC] = fire && !cur_cq && ecc_uncorr_i && !abort_ff;
  assign ev[FCFB_STK_IG_ECC] = ig_ecc_fail_i;
  assign sticky_wr = wr_acc && paddr_i == FCFB_STICKY_ADDR;

  generate
    for (genvar i = 0; i < FCFB_STK_N; i++) begin : g_stat
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          stk_ff[i] <= 1'b0;
          cnt_ff[i] <= '0;
        end else begin
          if (ev[i]) begin
            stk_ff[i] <= 1'b1;
            cnt_ff[i] <= cnt_ff[i] + 1'b1;
          end else if (sticky_wr && pwdata_i[i]) begin
            stk_ff[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ============================================================
  // apb slave
  // ============================================================
  assign wr_acc = psel_i && penable_i && pwrite_i && !pready_ff;

  always_comb begin
    rd = '0;
    rd_ok = 1'b1;
    case (paddr_i)
      FCFB_CTRL_ADDR: rd = ctrl_ff;
      FCFB_THR_ADDR: rd = thr_ff;
      FCFB_CQ_PART_ADDR: rd = cqp_ff;
      FCFB_DQ_PART_ADDR: rd = dqp_ff;
      FCFB_STATUS_ADDR: rd = {{(24-2*AW){1'b0}}, eee_ff, paused_ff,
                              host_pause_req_o, cq_full, dq_full,
                              cq_lvl, dq_lvl};
      FCFB_STICKY_ADDR: rd = {{(32-FCFB_STK_N){1'b0}}, stk_ff};
      FCFB_DROP_CQ_OVF_ADDR: rd = cnt_ff[FCFB_STK_CQ_OVF];
      FCFB_DROP_DQ_OVF_ADDR: rd = cnt_ff[FCFB_STK_DQ_OVF];
      FCFB_DROP_CQ_ECC_ADDR: rd = cnt_ff[FCFB_STK_CQ_ECC];
      FCFB_DROP_DQ_ECC_ADDR: rd = cnt_ff[FCFB_STK_DQ_ECC];
      FCFB_DROP_IG_ECC_ADDR: rd = cnt_ff[FCFB_STK_IG_ECC];
      FCFB_LPI_WAKE_ADDR: rd = wake_ff;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff <= FCFB_CTRL_RST;
      thr_ff <= {7'h00, FCFB_XON_RST, 7'h00, FCFB_XOFF_RST};
      cqp_ff <= {7'h00, FCFB_CQ_END_RST, 7'h00, FCFB_CQ_START_RST};
      dqp_ff <= {7'h00, FCFB_DQ_END_RST, 7'h00, FCFB_DQ_START_RST};
      wake_ff <= {16'h0000, FCFB_WAKE_RST};
    end else if (wr_acc) begin
      case (paddr_i)
        FCFB_CTRL_ADDR: ctrl_ff <= pwdata_i & 32'h0000003F;
        FCFB_THR_ADDR: thr_ff <= pwdata_i & 32'h01FF01FF;
        FCFB_CQ_PART_ADDR: cqp_ff <= pwdata_i & 32'h01FF01FF;
        FCFB_DQ_PART_ADDR: dqp_ff <= pwdata_i & 32'h01FF01FF;
        FCFB_LPI_WAKE_ADDR: wake_ff <= pwdata_i & 32'h0000FFFF;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (psel_i && penable_i && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= !rd_ok;
      prdata_ff <= pwrite_i ? '0 : rd;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign prdata_o = prdata_ff;

endmodule

// >>> tb/fcfb_egress_checker.sv
`timescale 1ns/1ps
module fcfb_egress_checker
  import fcfb_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // line stream
  input wire logic out_valid_o,
  input wire fcfb_word_t out_word_o,
  input wire logic out_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ============================================================
  // apb access
  sequence s_wait;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_answer;
    pready_o && psel_i && penable_i;
  endsequence
  apb_wait_a: assert property (s_wait |=> s_answer)
    else $error("apb answer missing");
  apb_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  apb_access_a: assert property (pready_o |-> s_answer and $past(penable_i))
    else $error("pready outside access");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  err_pulse_a: assert property (pslverr_o |=> !pslverr_o)
    else $error("pslverr held");
  err_rdata_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("refused read data not zero");
  // ============================================================
  // line stream
  out_hold_a: assert property (out_valid_o && !out_ready_i |=>
    out_valid_o && $stable(out_word_o))
    else $error("output word not held");
  out_drop_a: assert property ($fell(out_valid_o) |-> $past(out_ready_i))
    else $error("output valid dropped unaccepted");
endmodule

// >>> tb/fcfb_line_sink.sv
`timescale 1ns/1ps
module fcfb_line_sink
  import fcfb_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // stream from buffer
  input wire logic stall_i,
  input wire logic out_valid_i,
  input wire fcfb_word_t out_word_i,
  output logic out_ready_o,
  // tallies
  output logic [15:0] words_o,
  output logic [15:0] ctrls_o
);
  logic slow_ff;
  // ============================================================
  // slow acceptance, every other cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slow_ff <= 1'b0;
      words_o <= 16'h0000;
      ctrls_o <= 16'h0000;
    end else begin
      slow_ff <= !slow_ff;
      if (out_valid_i && out_ready_o) begin
        words_o <= words_o + 16'h0001;
        ctrls_o <= ctrls_o + 16'(out_word_i.ctrl);
      end
    end
  end
  assign out_ready_o = slow_ff && !stall_i;
endmodule

// >>> tb/fcfb_bench.sv
`timescale 1ns/1ps
module fcfb_bench;
  import fcfb_pkg::*;
  logic clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic in_valid_i, in_ready_o, out_valid_o, out_abort_o, out_ready_i, e;
  logic ig_ecc_fail_i, line_pause_i, host_pause_req_o, lpi_active_o, stall;
  logic ecc_uncorr_i;
  logic [15:0] line_quanta_i, words, ctrls;
  fcfb_word_t in_word_i, out_word_o;
  int fails, checks_done, cycles, aborts;
  fcfb_egress fcfb_egress_i (.clk_i, .arst_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .in_valid_i, .in_word_i, .in_ready_o, .out_valid_o, .out_word_o,
    .out_abort_o, .out_ready_i, .ecc_uncorr_i, .ig_ecc_fail_i,
    .line_pause_i, .line_quanta_i, .host_pause_req_o, .lpi_active_o);
  fcfb_line_sink fcfb_line_sink_i (.clk_i, .arst_n_i, .stall_i(stall),
    .out_valid_i(out_valid_o), .out_word_i(out_word_o),
    .out_ready_o(out_ready_i), .words_o(words), .ctrls_o(ctrls));
  // ============================================================
  // common tasks
  task automatic summarize();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("read data", x, q);
  endtask
  task automatic push(input logic c, input int n);
    fcfb_word_t w;
    for (int i = 0; i < n; i++) begin
      w = '0;
      w.data = 64'(i);
      w.sof = (i == 0);
      w.eof = (i == n - 1);
      w.ctrl = c;
      in_word_i <= w;
      in_valid_i <= 1'b1;
      do @(posedge clk_i); while (in_ready_o !== 1'b1);
    end
    in_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // ============================================================
  // scenarios
  task automatic t_reset();
    rd(FCFB_CTRL_ADDR, 32'h0000000F);
    rd(FCFB_THR_ADDR, 32'h00800100);
    rd(FCFB_CQ_PART_ADDR, 32'h003F0000);
    rd(FCFB_DQ_PART_ADDR, 32'h01FF0040);
    rd(FCFB_DROP_IG_ECC_ADDR, 32'h00000000);
  endtask
  task automatic t_refuse();
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped error", 32'h1, 32'(e));
    apb(1'b1, FCFB_CTRL_ADDR, 32'h00000002);
    rd(FCFB_CTRL_ADDR, 32'h00000002);
    apb(1'b1, FCFB_CTRL_ADDR, 32'h0000000F);
  endtask
  task automatic t_ecc();
    ig_ecc_fail_i <= 1'b1;
    @(posedge clk_i);
    ig_ecc_fail_i <= 1'b0;
    @(posedge clk_i);
    rd(FCFB_DROP_IG_ECC_ADDR, 32'h00000001);
    rd(FCFB_STICKY_ADDR, 32'h00000010);
    apb(1'b1, FCFB_STICKY_ADDR, 32'h00000010);
    rd(FCFB_STICKY_ADDR, 32'h00000000);
  endtask
  task automatic t_flow();
    apb(1'b1, FCFB_THR_ADDR, 32'h00020004);
    stall <= 1'b1;
    push(1'b1, 2);
    // host may finish a started frame after xoff
    push(1'b0, 8);
    chk("pause request", 32'h1, 32'(host_pause_req_o));
    stall <= 1'b0;
    for (int i = 0; i < 300 && words != 16'd10; i++)
      @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    chk("words out", 32'd10, 32'(words));
    chk("control words", 32'd2, 32'(ctrls));
    chk("pause release", 32'h0, 32'(host_pause_req_o));
  endtask
  task automatic t_pause();
    int w0;
    w0 = words;
    line_quanta_i <= 16'h0004;
    line_pause_i <= 1'b1;
    @(posedge clk_i);
    line_pause_i <= 1'b0;
    push(1'b0, 2);
    chk("merged request", 32'h1, 32'(host_pause_req_o));
    chk("paused drain", 32'(w0), 32'(words));
    repeat (60) @(posedge clk_i);
    chk("resumed drain", 32'(w0 + 2), 32'(words));
    chk("request released", 32'h0, 32'(host_pause_req_o));
  endtask
  task automatic t_abort();
    int w0;
    w0 = words;
    ecc_uncorr_i <= 1'b1;
    push(1'b0, 2);
    for (int i = 0; i < 100 && words != w0 + 2; i++)
      @(posedge clk_i);
    ecc_uncorr_i <= 1'b0;
    chk("aborted words", 32'd2, 32'(aborts));
    rd(FCFB_DROP_DQ_ECC_ADDR, 32'h00000001);
    rd(FCFB_STICKY_ADDR, 32'h00000008);
  endtask
  task automatic t_eee();
    apb(1'b1, FCFB_CTRL_ADDR, 32'h0000001F);
    chk("lpi entered", 32'h1, 32'(lpi_active_o));
    apb(1'b1, FCFB_CTRL_ADDR, 32'h0000000F);
    repeat (2) @(posedge clk_i);
    chk("lpi left", 32'h0, 32'(lpi_active_o));
  endtask
  // ============================================================
  // clock, reset, run
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  always @(posedge clk_i) begin
    if (out_valid_o && out_ready_i && out_abort_o)
      aborts++;
  end
  initial begin
    {arst_n_i, psel_i, penable_i, pwrite_i, in_valid_i} = '0;
    {ig_ecc_fail_i, line_pause_i, stall, ecc_uncorr_i} = '0;
    paddr_i = '0;
    pwdata_i = '0;
    line_quanta_i = '0;
    in_word_i = '0;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_refuse();
    t_ecc();
    t_flow();
    t_pause();
    t_abort();
    t_eee();
    summarize();
  end
endmodule
bind fcfb_egress fcfb_egress_checker fcfb_egress_checker_i (.clk_i,
  .arst_n_i, .psel_i, .penable_i, .pwrite_i, .prdata_o, .pready_o,
  .pslverr_o, .out_valid_o, .out_word_o, .out_ready_i);
